// file: hw/insn_decoder.sv
// instruction decoder and four-period cycle sequencer
// assumes program memory presents i_fetch_word, held for a whole cycle,
// and the datapath returns i_cond_true during the first cycle's last phase
`timescale 1ns/1ps

module insn_decoder
	import insn_decode_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic               i_reset_n,
	input  wire logic [WORD_W-1:0]  i_fetch_word,
	input  wire logic               i_cond_true,
	output logic [1:0]              o_phase,
	output logic                    o_cycle_end,
	output logic                    o_fetch_req,
	output logic [1:0]              o_class,
	output logic                    o_dest_file,
	output logic                    o_dest_acc,
	output logic [FILE_W-1:0]       o_file_addr,
	output logic [BIT_W-1:0]        o_bit_sel,
	output logic [LIT8_W-1:0]       o_lit8,
	output logic [LIT11_W-1:0]      o_lit11,
	output logic [3:0]              o_byte_op,
	output logic [1:0]              o_bit_op,
	output logic                    o_is_nop,
	output logic                    o_is_flush,
	output logic                    o_standby,
	output logic                    o_wdt_clear,
	output logic                    o_flags_update,
	output logic                    o_timeout_flag,
	output logic                    o_powerdown_flag
);

	////////////////////////////////////////////////////////////////////////
	// field split
	logic [1:0]         grp;
	logic [3:0]         byte_op;
	logic [1:0]         bit_op;
	logic               dsel;
	logic [FILE_W-1:0]  faddr;
	logic [BIT_W-1:0]   bsel;
	logic [LIT8_W-1:0]  lit8;
	logic [LIT11_W-1:0] lit11;

	insn_field_split u_split (
		.i_word      (i_fetch_word),
		.o_group     (grp),
		.o_byte_op   (byte_op),
		.o_bit_op    (bit_op),
		.o_dest_sel  (dsel),
		.o_file_addr (faddr),
		.o_bit_sel   (bsel),
		.o_lit8      (lit8),
		.o_lit11     (lit11)
	);

	////////////////////////////////////////////////////////////////////////
	// phase counter
	logic [1:0] phase_q;
	logic [1:0] phase_d;
	wire        last_phase = (phase_q == PHASE_LAST);

	assign phase_d = last_phase ? PHASE_RST : 2'(phase_q + 2'h1);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			phase_q <= PHASE_RST;
		else
			phase_q <= phase_d;
	end

	////////////////////////////////////////////////////////////////////////
	// classification and two-cycle detection
	insn_class_e cls;
	wire is_ctl_zero = (grp == GRP_BYTE) && (byte_op == 4'h0)
		&& !dsel;

	assign cls = (grp == GRP_BYTE) ? CLS_BYTE :
		(grp == GRP_BIT) ? CLS_BIT : CLS_LITCTL;

	wire is_standby = (i_fetch_word == ENC_STANDBY);
	wire is_wdt_clr = (i_fetch_word == ENC_WDT_CLR);

	wire is_skip = ((grp == GRP_BYTE) &&
		((byte_op == OP_DECFSZ) || (byte_op == OP_INCFSZ))) ||
		((grp == GRP_BIT) &&
		((bit_op == BOP_TSTC) || (bit_op == BOP_TSTS)));
	wire is_pc_chg = (grp == GRP_JUMP) ||
		((grp == GRP_LIT) && (i_fetch_word[11:10] == LOP_RETLW)) ||
		(i_fetch_word == ENC_RETURN) || (i_fetch_word == ENC_RETINT);
	wire two_cycle = is_pc_chg || (is_skip && i_cond_true);

	// no-operation ignores bits 5 and 6
	wire is_nop_enc = is_ctl_zero && (i_fetch_word[4:0] == 5'h00);

	////////////////////////////////////////////////////////////////////////
	// flush and status flags
	logic flush_q;
	logic flush_d;
	logic to_q;
	logic to_d;
	logic pd_q;
	logic pd_d;
	wire  exec_end = last_phase && !flush_q;

	assign flush_d = last_phase ? (exec_end && two_cycle) : flush_q;
	assign to_d = (exec_end && (is_standby || is_wdt_clr)) ? 1'b1 : to_q;
	assign pd_d = (exec_end && is_standby) ? 1'b0 :
		(exec_end && is_wdt_clr) ? 1'b1 : pd_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flush_q <= 1'b0;
			to_q    <= 1'b1;
			pd_q    <= 1'b1;
		end else begin
			flush_q <= flush_d;
			to_q    <= to_d;
			pd_q    <= pd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered decode outputs, captured at the end of each cycle's first phase
	wire load = (phase_q == PHASE_RST);
	wire kill = flush_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_class     <= 2'h0;
			o_dest_file <= 1'b0;
			o_dest_acc  <= 1'b0;
			o_file_addr <= '0;
			o_bit_sel   <= '0;
			o_lit8      <= '0;
			o_lit11     <= '0;
			o_byte_op   <= 4'h0;
			o_bit_op    <= 2'h0;
			o_is_nop    <= 1'b1;
			o_is_flush  <= 1'b0;
		end else if (load) begin
			o_class     <= kill ? 2'h0 : 2'(cls);
			o_dest_file <= !kill && (cls == CLS_BYTE) && dsel;
			o_dest_acc  <= !kill && (cls == CLS_BYTE) && !dsel;
			o_file_addr <= kill ? '0 : faddr;
			o_bit_sel   <= kill ? '0 : bsel;
			o_lit8      <= kill ? '0 : lit8;
			o_lit11     <= kill ? '0 : lit11;
			o_byte_op   <= kill ? 4'h0 : byte_op;
			o_bit_op    <= kill ? 2'h0 : bit_op;
			o_is_nop    <= kill || is_nop_enc;
			o_is_flush  <= kill;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_phase          <= PHASE_RST;
			o_cycle_end      <= 1'b0;
			o_fetch_req      <= 1'b0;
			o_standby        <= 1'b0;
			o_wdt_clear      <= 1'b0;
			o_flags_update   <= 1'b0;
			o_timeout_flag   <= 1'b1;
			o_powerdown_flag <= 1'b1;
		end else begin
			o_phase          <= phase_d;
			o_cycle_end      <= (phase_d == PHASE_LAST);
			o_fetch_req      <= (phase_d == PHASE_LAST);
			o_standby        <= exec_end && is_standby;
			o_wdt_clear      <= exec_end && is_wdt_clr;
			o_flags_update   <= exec_end && (is_standby || is_wdt_clr);
			o_timeout_flag   <= to_d;
			o_powerdown_flag <= pd_d;
		end
	end

endmodule : insn_decoder

// file: inc/insn_decode_pkg.sv
// constants for the 14-bit instruction decoder and its cycle sequencer
// assumes one system clock at 50 MHz, used as the oscillator period
package insn_decode_pkg;
	localparam int WORD_W        = 14;
	localparam int FILE_W        = 7;
	localparam int BIT_W         = 3;
	localparam int LIT8_W        = 8;
	localparam int LIT11_W       = 11;
	localparam int OSC_PER_CYC   = 4;
	localparam int PHASE_W       = 2;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_RST  = 2'h0;
	localparam logic [1:0] GRP_BYTE   = 2'h0;
	localparam logic [1:0] GRP_BIT    = 2'h1;
	localparam logic [1:0] GRP_JUMP   = 2'h2;
	localparam logic [1:0] GRP_LIT    = 2'h3;
	localparam logic [13:0] ENC_NOP     = 14'h0000;
	localparam logic [13:0] ENC_STANDBY = 14'h0063;
	localparam logic [13:0] ENC_WDT_CLR = 14'h0064;
	localparam logic [13:0] ENC_RETURN  = 14'h0008;
	localparam logic [13:0] ENC_RETINT  = 14'h0009;
	localparam logic [3:0]  OP_DECFSZ   = 4'hB;
	localparam logic [3:0]  OP_INCFSZ   = 4'hF;
	localparam logic [1:0]  BOP_TSTC    = 2'h2;
	localparam logic [1:0]  BOP_TSTS    = 2'h3;
	localparam logic [1:0]  LOP_RETLW   = 2'h1;
	typedef enum logic [1:0] {
		CLS_BYTE,
		CLS_BIT,
		CLS_LITCTL
	} insn_class_e;
endpackage : insn_decode_pkg

// file: hw/insn_field_split.sv
// pure field extraction of one 14-bit instruction word
// assumes the caller registers the results
`timescale 1ns/1ps
module insn_field_split
	import insn_decode_pkg::*;
(
	input  wire logic [WORD_W-1:0]  i_word,
	output wire logic [1:0]         o_group,
	output wire logic [3:0]         o_byte_op,
	output wire logic [1:0]         o_bit_op,
	output wire logic               o_dest_sel,
	output wire logic [FILE_W-1:0]  o_file_addr,
	output wire logic [BIT_W-1:0]   o_bit_sel,
	output wire logic [LIT8_W-1:0]  o_lit8,
	output wire logic [LIT11_W-1:0] o_lit11
);
	assign o_group     = i_word[13:12];
	assign o_byte_op   = i_word[11:8];
	assign o_bit_op    = i_word[11:10];
	assign o_dest_sel  = i_word[7];
	assign o_file_addr = i_word[FILE_W-1:0];
	assign o_bit_sel   = i_word[9:7];
	assign o_lit8      = i_word[LIT8_W-1:0];
	assign o_lit11     = i_word[LIT11_W-1:0];
endmodule : insn_field_split

// file: dv/prog_mem.sv
// program memory model, one word per instruction cycle
// assumes the bench fills mem before reset is released
`timescale 1ns/1ps
module prog_mem
	import insn_decode_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_reset_n,
	input  wire logic          i_fetch_req,
	output logic [WORD_W-1:0]  o_word
);
	logic [WORD_W-1:0] mem [0:127];
	logic [6:0]        pc_q;
	assign o_word = mem[pc_q];
	// advances even when the slot is flushed
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			pc_q <= 7'h00;
		else if (i_fetch_req)
			pc_q <= #1 pc_q + 7'h01;
	end
endmodule : prog_mem

// file: dv/insn_decoder_chk.sv
// timing and flag checks on the decoder ports
// assumes it is bound onto insn_decoder
`timescale 1ns/1ps
module insn_decoder_chk
	import insn_decode_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_reset_n,
	input wire logic [1:0] o_phase,
	input wire logic       o_cycle_end,
	input wire logic       o_fetch_req,
	input wire logic       o_dest_file,
	input wire logic       o_dest_acc,
	input wire logic       o_is_nop,
	input wire logic       o_is_flush,
	input wire logic       o_standby,
	input wire logic       o_wdt_clear,
	input wire logic       o_flags_update,
	input wire logic       o_timeout_flag,
	input wire logic       o_powerdown_flag
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	////////////////////////////////////////////////////////////////
	a_end_phase: assert property (
		o_cycle_end == (o_phase == PHASE_LAST)) else $error("end off phase");
	a_fetch_end: assert property (
		o_fetch_req == o_cycle_end) else $error("fetch not at end");
	a_four_periods: assert property (
		o_cycle_end |=> !o_cycle_end [*3] ##1 o_cycle_end)
		else $error("cycle not four periods");
	a_dest_excl: assert property (
		!(o_dest_file && o_dest_acc)) else $error("both destinations");
	a_flush_nop: assert property (
		o_is_flush |-> o_is_nop && !o_dest_file && !o_dest_acc)
		else $error("flush slot not empty");
	a_standby_flags: assert property (
		o_standby |=> o_timeout_flag && !o_powerdown_flag)
		else $error("standby flags wrong");
	a_wdt_flags: assert property (
		o_wdt_clear |=> o_timeout_flag && o_powerdown_flag)
		else $error("watchdog clear flags wrong");
	a_update_cause: assert property (
		o_flags_update == (o_standby || o_wdt_clear))
		else $error("flag update without cause");
	a_flags_hold: assert property (
		$changed({o_timeout_flag, o_powerdown_flag}) |->
		o_flags_update) else $error("flags moved alone");
	a_pulse_phase: assert property (
		(o_standby || o_wdt_clear) |-> (o_phase == PHASE_RST)
		##1 (!o_standby && !o_wdt_clear)) else $error("pulse misplaced");
	c_standby: cover property (o_standby);
	c_wdt: cover property (o_wdt_clear);
	c_flush: cover property (o_is_flush);
endmodule : insn_decoder_chk
bind insn_decoder insn_decoder_chk u_chk (.i_clk, .i_reset_n, .o_phase,
	.o_cycle_end, .o_fetch_req, .o_dest_file, .o_dest_acc, .o_is_nop,
	.o_is_flush, .o_standby, .o_wdt_clear, .o_flags_update,
	.o_timeout_flag, .o_powerdown_flag);

// file: dv/tb_top.sv
// self-checking bench: corner words, then random words
// assumes prog_mem as word source and the bound checker
`timescale 1ns/1ps
module tb_top import insn_decode_pkg::*;;
	localparam int NW = 96;
	localparam logic [13:0] CW [16] = '{14'h0063, 14'h0064, 14'h0063,
		14'h0060, 14'h0008, 14'h07FF, 14'h0BA5, 14'h0FFF, 14'h1C10,
		14'h1B80, 14'h3555, 14'h2ABC, 14'h0064, 14'h3400, 14'h0009, 14'h0F85};
	// skip test results for the corner words, one bit per word
	localparam logic [15:0] CC = 16'h8240;
	logic i_clk, i_reset_n, i_cond_true, o_cycle_end, o_fetch_req;
	logic o_dest_file, o_dest_acc, o_is_nop, o_is_flush, o_standby;
	logic o_wdt_clear, o_flags_update, o_timeout_flag, o_powerdown_flag;
	logic [1:0] o_phase, o_class, o_bit_op, s;
	logic [3:0] o_byte_op;
	logic [6:0] o_file_addr;
	logic [2:0] o_bit_sel;
	logic [7:0] o_lit8;
	logic [10:0] o_lit11;
	logic [13:0] i_fetch_word, w;
	logic [15:0] rnd;
	logic fl, c, tq, pq;
	logic [15:0] ev, gv;
	int bad_count, total_checks, n, k;
	insn_decoder u_dut (.i_clk, .i_reset_n, .i_fetch_word, .i_cond_true,
		.o_phase, .o_cycle_end, .o_fetch_req, .o_class, .o_dest_file,
		.o_dest_acc, .o_file_addr, .o_bit_sel, .o_lit8, .o_lit11, .o_byte_op,
		.o_bit_op, .o_is_nop, .o_is_flush, .o_standby, .o_wdt_clear,
		.o_flags_update, .o_timeout_flag, .o_powerdown_flag);
	prog_mem u_mem (.i_clk, .i_reset_n, .i_fetch_req(o_fetch_req),
		.o_word(i_fetch_word));
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	function automatic logic two_cyc(logic [13:0] v, logic t);
		return v == ENC_RETURN || v == ENC_RETINT || v[13:12] == GRP_JUMP ||
			v[13:10] == 4'hD || (t && v[13:11] == 3'h3) ||
			(t && v[13:12] == 2'h0 && v[11:8] inside {OP_DECFSZ, OP_INCFSZ});
	endfunction : two_cyc
	function automatic logic [15:0] key(logic [13:0] v, logic [1:0] g, logic o);
		case (g)
			2'h0: return o ? {3'h0, o_byte_op, o_dest_acc, o_dest_file,
				o_file_addr} : {3'h0, v[11:8], ~v[7], v[7:0]};
			2'h1: return o ? {4'h0, o_bit_op, o_bit_sel, o_file_addr} :
				{4'h0, v[11:0]};
			2'h2: return o ? {5'h0, o_lit11} : {5'h0, v[10:0]};
			default: return o ? {8'h0, o_lit8} : {8'h0, v[7:0]};
		endcase
	endfunction : key
	task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : cmp
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		{i_reset_n, i_cond_true, fl, tq, pq, rnd} = {5'h03, 16'h0060};
		for (n = 0; n < NW; n++) begin
			rnd = lfsr(rnd);
			u_mem.mem[n] = n < 16 ? CW[n] : rnd[13:0];
		end
		repeat (10) @(posedge i_clk);
		#1;
		gv = 16'({o_phase, o_is_nop, o_timeout_flag, o_powerdown_flag});
		cmp("reset", 16'h0007, gv);
		gv = 16'({o_class, o_dest_file, o_dest_acc, o_is_flush, o_standby,
			o_wdt_clear, o_flags_update, o_cycle_end, o_fetch_req});
		cmp("reset idle", 16'h0000, gv);
		i_reset_n = 1'b1;
		for (n = 0; n < NW; n++) begin
			for (k = 0; k < 8 && o_fetch_req !== 1'b1; k++) @(posedge i_clk) #1;
			if (o_fetch_req !== 1'b1) begin
				cmp("fetch_req", 16'h0001, 16'(o_fetch_req));
				report_and_stop();
			end
			w = fl ? ENC_NOP : u_mem.mem[n];
			s = w[13] ? GRP_JUMP : w[13:12];
			cmp("class", 16'(s), 16'(o_class));
			ev = fl ? 16'h0000 : key(w, w[13:12], 1'b0);
			gv = key(w, w[13:12], 1'b1);
			cmp("fields", ev, gv);
			ev = 16'({fl || ((w & 14'h3F9F) == 14'h0000), fl});
			gv = 16'({o_is_nop, o_is_flush});
			cmp("nop", ev, gv);
			ev = 16'({tq, pq});
			gv = 16'({o_timeout_flag, o_powerdown_flag});
			cmp("flags", ev, gv);
			rnd = lfsr(rnd);
			c = n < 16 ? CC[n] : rnd[3];
			i_cond_true = c;
			@(posedge i_clk) #1;
			ev = 16'({w == ENC_STANDBY, w == ENC_WDT_CLR});
			gv = 16'({o_standby, o_wdt_clear});
			cmp("pulse", ev, gv);
			if (w == ENC_STANDBY || w == ENC_WDT_CLR)
				{tq, pq} = {1'b1, w == ENC_WDT_CLR};
			fl = !fl && two_cyc(w, c);
			if (n == 15)
				$display("corner words done");
		end
		$display("random words done");
		report_and_stop();
	end
endmodule : tb_top
